// ==== inc/psm_pkg.sv ====
package psm_pkg;

    // ----------------------------------------------------------------
    // Output bit positions inside the packed output vector
    // ----------------------------------------------------------------
    localparam int PSM_OUT_A = 0;
    localparam int PSM_OUT_B = 1;
    localparam int PSM_OUT_C = 2;
    localparam int PSM_OUT_D = 3;
    localparam int PSM_OUT_E = 4;
    localparam int PSM_OUT_F = 5;
    localparam int PSM_OUT_N = 6;

    // ----------------------------------------------------------------
    // Reset values and default widths
    // ----------------------------------------------------------------
    localparam logic [5:0] PSM_OUTS_RST = 6'h00;
    localparam logic       PSM_ODD_RST  = 1'h0;
    localparam int         PSM_DB_W     = 8;
    localparam int         PSM_SRC_N    = 4;

    // Pending dead-band wait
    typedef enum logic [1:0] {
        PSM_HOLD_NONE,
        PSM_HOLD_RISE,
        PSM_HOLD_FALL
    } psm_hold_t;

    // Primary group for the mode and period parity
    function automatic logic [5:0] psm_prim_mask(input logic pp,
                                                 input logic odd);
        logic [5:0] m;
        m = '0;
        if (!pp)
            m[PSM_OUT_A] = 1'b1;
        else if (odd) begin
            m[PSM_OUT_A] = 1'b1;
            m[PSM_OUT_C] = 1'b1;
        end else begin
            m[PSM_OUT_B] = 1'b1;
            m[PSM_OUT_D] = 1'b1;
        end
        return m;
    endfunction

    // Complementary output for the mode and period parity
    function automatic logic [5:0] psm_comp_mask(input logic pp,
                                                 input logic odd);
        logic [5:0] m;
        m = '0;
        if (!pp)
            m[PSM_OUT_B] = 1'b1;
        else if (odd)
            m[PSM_OUT_E] = 1'b1;
        else
            m[PSM_OUT_F] = 1'b1;
        return m;
    endfunction

    // Outputs that pulse-skipping may drive
    localparam logic [5:0] PSM_SKIP_USED = 6'h03;

endpackage

// ==== inc/psm_db_if.sv ====
`timescale 1ns/10ps
interface psm_db_if #(parameter int DB_W = 8);
    logic            start;
    logic [DB_W-1:0] len;
    logic            done;

    modport ctrl  (output start, output len, input done);
    modport timer (input start, input len, output done);
endinterface

// ==== src/psm_dband.sv ====
`timescale 1ns/10ps
module psm_dband
    import psm_pkg::*;
#(
    parameter int DB_W = PSM_DB_W
)(
    input wire logic core_clk,
    input wire logic rst_b,
    psm_db_if.timer  db
);

    typedef struct packed {
        logic [DB_W-1:0] cnt;
    } psm_db_state_t;

    psm_db_state_t s;
    psm_db_state_t next_s;

    if (DB_W < 1) begin : g_chk
        $error("psm_dband: DB_W must be at least 1");
    end

    // ----------------------------------------------------------------
    // Dead-band down counter, restarted by every start
    // ----------------------------------------------------------------

    // Done in the last counted cycle
    assign db.done = (s.cnt == DB_W'(1));

    // Load or count down; zero length still waits one cycle
    always_comb begin
        next_s = s;
        if (db.start)
            next_s.cnt = (db.len == '0) ? DB_W'(1) : db.len;
        else if (s.cnt != '0)
            next_s.cnt = s.cnt - DB_W'(1);
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

endmodule

// ==== src/psm_gen.sv ====
`timescale 1ns/10ps
// How it works
// RULE1: Push-pull uses six outputs, alternating odd/even.
// RULE2: Primary on A-D, complement on E-F.
// RULE3: A mirrors C, B mirrors D.
// RULE4: Odd rise: E off, dead band, A/C on.
// RULE5: Odd fall: A/C off, dead band, E on.
// RULE6: Even rise: F off, dead band, B/D on.
// RULE7: Even fall: B/D off, dead band, F on.
// RULE8: Skip mode pulses only if source high.
// RULE9: Skip mode rise timed by phase compare.
// RULE10: Skip mode fall follows fall events directly.
// RULE11: Skip mode uses only A and B.
// RULE12: Qualified rise: B off, dead band, A on.
// RULE13: Skip fall: A off, dead band, B on.
// RULE14: Outside source decides which periods pulse.
// RULE15: Parity flag toggles per period, resets odd-first.
module psm_gen
    import psm_pkg::*;
#(
    parameter int DB_W  = PSM_DB_W,
    parameter int SRC_N = PSM_SRC_N
)(
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             enable,
    input  wire logic             push_pull_mode,
    input  wire logic             period_evt,
    input  wire logic             rise_evt,
    input  wire logic             fall_evt,
    input  wire logic [SRC_N-1:0] rise_src,
    input  wire logic [SRC_N-1:0] rise_src_en,
    input  wire logic             db_rise_en,
    input  wire logic             db_fall_en,
    input  wire logic [DB_W-1:0]  db_rise_len,
    input  wire logic [DB_W-1:0]  db_fall_len,
    output logic                  primary_out_a,
    output logic                  primary_out_b,
    output logic                  primary_out_c,
    output logic                  primary_out_d,
    output logic                  complement_out_e,
    output logic                  complement_out_f
);

    typedef struct packed {
        logic [5:0] outs;
        logic       odd;
        logic       qual;
        psm_hold_t  hold;
        logic [5:0] pmask;
        logic [5:0] cmask;
    } psm_state_t;

    psm_state_t  s;
    psm_state_t  next_s;
    logic        odd_now;
    logic        qual_now;
    logic        rise_take;
    logic [5:0]  pm;
    logic [5:0]  cm;

    psm_db_if #(.DB_W(DB_W)) db ();

    if (DB_W < 1 || SRC_N < 1) begin : g_chk
        $error("psm_gen: DB_W and SRC_N must be at least 1");
    end

    // ----------------------------------------------------------------
    // Dead-band timer
    // ----------------------------------------------------------------

    // Shared by rising and falling dead band
    psm_dband #(.DB_W(DB_W)) u_dband (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .db       (db.timer)
    );

    // ----------------------------------------------------------------
    // Waveform sequencing
    // ----------------------------------------------------------------

    // Parity, qualification, edge events and dead-band completion
    always_comb begin
        next_s    = s;
        odd_now   = s.odd;
        qual_now  = s.qual;
        rise_take = 1'b0;
        db.start  = 1'b0;
        db.len    = '0;
        pm        = '0;
        cm        = '0;
        if (!enable) begin
            next_s      = '0;
            next_s.outs = PSM_OUTS_RST;
            next_s.odd  = PSM_ODD_RST;
        end else begin
            if (period_evt) begin
                odd_now  = ~s.odd; // RULE15
                qual_now = |(rise_src & rise_src_en); // RULE8
            end
            next_s.odd  = odd_now;
            next_s.qual = qual_now;
            // Groups alternate with parity in push-pull
            pm = psm_prim_mask(push_pull_mode, odd_now); // RULE1 RULE2
            cm = psm_comp_mask(push_pull_mode, odd_now); // RULE2 RULE11

            // End of a dead band drives the waiting group active
            case (s.hold)
                PSM_HOLD_RISE: begin
                    if (db.done) begin
                        next_s.outs = s.outs | s.pmask;
                        next_s.hold = PSM_HOLD_NONE;
                    end
                end
                PSM_HOLD_FALL: begin
                    if (db.done) begin
                        next_s.outs = s.outs | s.cmask;
                        next_s.hold = PSM_HOLD_NONE;
                    end
                end
                default: next_s.hold = PSM_HOLD_NONE;
            endcase

            // Rising edge; skip mode only when qualified
            rise_take = rise_evt && (push_pull_mode || qual_now); // RULE9
            if (rise_take) begin
                next_s.qual  = 1'b0;
                next_s.pmask = pm;
                next_s.cmask = cm;
                next_s.outs  = next_s.outs & ~cm; // RULE4 RULE6 RULE12
                if (db_rise_en) begin
                    next_s.hold = PSM_HOLD_RISE;
                    db.start    = 1'b1;
                    db.len      = db_rise_len;
                end else begin
                    next_s.outs = next_s.outs | pm; // RULE4 RULE6 RULE12
                    next_s.hold = PSM_HOLD_NONE;
                end
            end

            // Falling edge is never qualified and wins a tie
            if (fall_evt) begin // RULE10
                next_s.pmask = pm;
                next_s.cmask = cm;
                next_s.outs  = next_s.outs & ~pm; // RULE5 RULE7 RULE13
                if (db_fall_en) begin
                    next_s.hold = PSM_HOLD_FALL;
                    db.start    = 1'b1;
                    db.len      = db_fall_len;
                end else begin
                    next_s.outs = next_s.outs | cm; // RULE5 RULE7 RULE13
                    next_s.hold = PSM_HOLD_NONE;
                end
            end

            // Skip mode never drives C to F
            if (!push_pull_mode)
                next_s.outs = next_s.outs & PSM_SKIP_USED; // RULE11
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s      <= '0;
            s.outs <= PSM_OUTS_RST;
            s.odd  <= PSM_ODD_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs, straight from the state register
    // ----------------------------------------------------------------
    assign primary_out_a    = s.outs[PSM_OUT_A];
    assign primary_out_b    = s.outs[PSM_OUT_B];
    assign primary_out_c    = s.outs[PSM_OUT_C]; // RULE3
    assign primary_out_d    = s.outs[PSM_OUT_D]; // RULE3
    assign complement_out_e = s.outs[PSM_OUT_E];
    assign complement_out_f = s.outs[PSM_OUT_F];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_ac_mirror: assert property ( // RULE3
        push_pull_mode && $past(push_pull_mode)
            |-> primary_out_a == primary_out_c)
        else $error("A and C differ in push-pull");

    a_bd_mirror: assert property ( // RULE3
        push_pull_mode && $past(push_pull_mode)
            |-> primary_out_b == primary_out_d)
        else $error("B and D differ in push-pull");

    a_skip_pins: assert property ( // RULE11
        enable && !push_pull_mode
            |=> !primary_out_c && !primary_out_d
                && !complement_out_e && !complement_out_f)
        else $error("Unused pin active in pulse-skipping");

    a_odd_rise: assert property ( // RULE4
        enable && push_pull_mode && rise_evt && odd_now && !fall_evt
            |=> !complement_out_e
                && (primary_out_a == !$past(db_rise_en)))
        else $error("Odd rising edge sequence wrong");

    a_even_rise: assert property ( // RULE6
        enable && push_pull_mode && rise_evt && !odd_now && !fall_evt
            |=> !complement_out_f
                && (primary_out_b == !$past(db_rise_en)))
        else $error("Even rising edge sequence wrong");

    a_odd_fall: assert property ( // RULE5
        enable && push_pull_mode && fall_evt && odd_now && !db_fall_en
            |=> complement_out_e && !primary_out_a && !primary_out_c)
        else $error("Odd falling edge sequence wrong");

    a_even_fall: assert property ( // RULE7
        enable && push_pull_mode && fall_evt && !odd_now && !db_fall_en
            |=> complement_out_f && !primary_out_b && !primary_out_d)
        else $error("Even falling edge sequence wrong");

    a_skip_fall: assert property ( // RULE13
        enable && !push_pull_mode && fall_evt && !db_fall_en
            |=> primary_out_b && !primary_out_a)
        else $error("Pulse-skipping falling edge wrong");

    a_skip_noq: assert property ( // RULE8
        enable && !push_pull_mode && rise_evt && !qual_now
            && !fall_evt && s.hold == PSM_HOLD_NONE
            |=> $stable(primary_out_a) && $stable(primary_out_b))
        else $error("Unqualified period produced a pulse");

    a_parity_flip: assert property ( // RULE15
        enable && period_evt |=> s.odd != $past(s.odd))
        else $error("Period parity did not toggle");

    a_rise_db: assert property ( // RULE12
        enable && !push_pull_mode && rise_evt && qual_now
            && !fall_evt && db_rise_en && !primary_out_a
            && db_rise_len == DB_W'(3) && !period_evt
            ##1 !fall_evt && !rise_evt && enable
            ##1 !fall_evt && !rise_evt && enable
            ##1 !fall_evt && !rise_evt && enable
            |-> !primary_out_a && !primary_out_b ##1 primary_out_a)
        else $error("Rising dead band length wrong");

endmodule

// ==== sim/psm_bridge_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bridge gate drivers: flag any leg pair that conducts together
// ----------------------------------------------------------------
module psm_bridge_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [5:0] gate,
    output logic            fault
);
    logic overlap;

    // High side and its rectifier or low side on at once
    assign overlap = (gate[0] & gate[4]) | (gate[2] & gate[4])
                   | (gate[1] & gate[5]) | (gate[3] & gate[5])
                   | (gate[0] & gate[1]);

    // Sticky shoot-through flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault <= 1'b0;
        end else if (overlap) begin
            fault <= 1'b1;
        end
    end
endmodule

// ==== sim/tb_psmc_pushpull_pulse_skip_modes.sv ====
`timescale 1ns/10ps
module tb_psmc_pushpull_pulse_skip_modes;
    logic       core_clk;
    logic       rst_b;
    logic       enable;
    logic       push_pull_mode;
    logic       period_evt;
    logic       rise_evt;
    logic       fall_evt;
    logic [3:0] rise_src;
    logic [3:0] rise_src_en;
    logic       db_rise_en;
    logic       db_fall_en;
    logic [7:0] db_rise_len;
    logic [7:0] db_fall_len;
    wire  [5:0] outs;
    logic       fault;
    int         error_cnt;
    int         num_checks;

    psm_gen psm_gen_i (
        .core_clk         (core_clk),
        .rst_b            (rst_b),
        .enable           (enable),
        .push_pull_mode   (push_pull_mode),
        .period_evt       (period_evt),
        .rise_evt         (rise_evt),
        .fall_evt         (fall_evt),
        .rise_src         (rise_src),
        .rise_src_en      (rise_src_en),
        .db_rise_en       (db_rise_en),
        .db_fall_en       (db_fall_en),
        .db_rise_len      (db_rise_len),
        .db_fall_len      (db_fall_len),
        .primary_out_a    (outs[0]),
        .primary_out_b    (outs[1]),
        .primary_out_c    (outs[2]),
        .primary_out_d    (outs[3]),
        .complement_out_e (outs[4]),
        .complement_out_f (outs[5])
    );

    psm_bridge_model psm_bridge_model_i (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .gate     (outs),
        .fault    (fault)
    );

    // Clock at 50 ns
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One-cycle event, returns one cycle after the answering edge
    task automatic pulse(input logic p, input logic r, input logic f);
        {period_evt, rise_evt, fall_evt} = {p, r, f};
        step(1);
        {period_evt, rise_evt, fall_evt} = 3'h0;
        step(1);
    endtask

    task automatic chk(input string name, input logic [5:0] exp,
                       input logic [5:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic look(input string name, input int n,
                        input logic [5:0] exp);
        step(n);
        chk(name, exp, outs);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_push_pull();
        push_pull_mode = 1'b1;
        db_rise_en = 1'b1;
        db_rise_len = 8'h02;
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0);
        look("odd rise off", 0, 6'h00);
        look("odd rise on", 1, 6'h05);
        look("odd rise mirror", 1, 6'h05);
        pulse(1'b0, 1'b0, 1'b1);
        look("odd fall", 0, 6'h10);
        db_fall_en = 1'b1;
        db_fall_len = 8'h02;
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0);
        look("even rise off", 0, 6'h10);
        look("even rise on", 2, 6'h1A);
        pulse(1'b0, 1'b0, 1'b1);
        look("even fall off", 0, 6'h10);
        look("even fall on", 1, 6'h30);
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0);
        look("third rise off", 0, 6'h20);
        look("third rise on", 2, 6'h25);
        pulse(1'b0, 1'b0, 1'b1);
        look("third fall off", 0, 6'h20);
        look("third fall on", 1, 6'h30);
        $display("test push_pull done");
    endtask

    task automatic test_skip();
        enable = 1'b0;
        look("disable clear", 1, 6'h00);
        push_pull_mode = 1'b0;
        enable = 1'b1;
        db_rise_len = 8'h03;
        db_fall_en = 1'b0;
        pulse(1'b0, 1'b0, 1'b1);
        look("skip fall alone", 0, 6'h02);
        rise_src = 4'h2;
        rise_src_en = 4'h2;
        pulse(1'b1, 1'b0, 1'b0);
        rise_src = 4'h0;
        pulse(1'b0, 1'b1, 1'b0);
        look("skip rise off", 0, 6'h00);
        look("skip rise wait", 1, 6'h00);
        look("skip rise on", 1, 6'h01);
        pulse(1'b0, 1'b0, 1'b1);
        look("skip fall", 0, 6'h02);
        pulse(1'b0, 1'b1, 1'b0);
        look("rise reused", 3, 6'h02);
        rise_src = 4'h1;
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0);
        look("rise masked src", 3, 6'h02);
        $display("test skip done");
    endtask

    task automatic test_reenable();
        enable = 1'b0;
        step(1);
        push_pull_mode = 1'b1;
        enable = 1'b1;
        db_rise_en = 1'b0;
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0);
        look("first period odd", 0, 6'h05);
        pulse(1'b0, 1'b0, 1'b1);
        look("plain odd fall", 0, 6'h10);
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0);
        look("plain even rise", 0, 6'h1A);
        pulse(1'b0, 1'b0, 1'b1);
        look("plain even fall", 0, 6'h30);
        chk("bridge overlap", 6'h00, {5'h00, fault});
        $display("test reenable done");
    endtask

    // Hang guard
    initial begin
        repeat (3000) @(posedge core_clk);
        $display("Error watchdog expected done seen hang");
        error_cnt++;
        summarize();
    end

    // Main sequence
    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst_b = 1'b0;
        enable = 1'b1;
        push_pull_mode = 1'b1;
        {period_evt, rise_evt, fall_evt} = 3'h0;
        rise_src = 4'h0;
        rise_src_en = 4'h0;
        db_rise_en = 1'b0;
        db_fall_en = 1'b0;
        db_rise_len = 8'h01;
        db_fall_len = 8'h01;
        step(6);
        rst_b = 1'b1;
        look("after reset", 0, 6'h00);
        test_push_pull();
        test_skip();
        test_reenable();
        summarize();
    end
endmodule
